// file: rsp_pkg.sv
// Shared constants, types and helpers for the RGB sync panel interface.
// Assumes a 10 MHz bus clock and a 32-bit AHB-Lite register port.
package rsp_pkg;

	// Bus decode
	localparam int         RSP_AW         = 8;      // Decoded address bits
	localparam logic [7:0] RSP_OFS_CTRL   = 8'h00;  // Enable, polarities, format
	localparam logic [7:0] RSP_OFS_HSYNC  = 8'h04;  // Line sync width
	localparam logic [7:0] RSP_OFS_HPORCH = 8'h08;  // Line back and front gaps
	localparam logic [7:0] RSP_OFS_HACT   = 8'h0c;  // Pixels per line
	localparam logic [7:0] RSP_OFS_VSYNC  = 8'h10;  // Frame sync width in lines
	localparam logic [7:0] RSP_OFS_VPORCH = 8'h14;  // Frame back and front gaps
	localparam logic [7:0] RSP_OFS_VACT   = 8'h18;  // Visible lines per frame
	localparam logic [7:0] RSP_OFS_CLKDIV = 8'h1c;  // Bus cycles per clock half period
	localparam logic [7:0] RSP_OFS_STATUS = 8'h20;  // Underrun, position, fill level
	localparam logic [7:0] RSP_OFS_DATA   = 8'h24;  // Pixel push, write only

	// Field positions
	localparam int RSP_CTRL_EN     = 0;   // Run the timing generator
	localparam int RSP_CTRL_PCLK   = 1;   // 1: launch on falling edge
	localparam int RSP_CTRL_HSPOL  = 2;   // Line sync active level
	localparam int RSP_CTRL_VSPOL  = 3;   // Frame sync active level
	localparam int RSP_CTRL_FMT    = 4;   // Two-bit pixel format
	localparam int RSP_LO_LSB      = 0;   // Low timing field
	localparam int RSP_HI_LSB      = 16;  // High timing field
	localparam int RSP_ST_UNDERRUN = 0;   // Sticky, write one to clear
	localparam int RSP_ST_VIS      = 1;   // Current line is a visible line
	localparam int RSP_ST_LVL_LSB  = 4;   // FIFO fill level
	localparam int RSP_ST_LINE_LSB = 16;  // Current line index

	// Widths
	localparam int RSP_TW       = 12;  // Timing field width
	localparam int RSP_PIX_W    = 24;  // Internal pixel word
	localparam int RSP_COLOUR_W = 18;  // Link colour lines
	localparam int RSP_FIFO_D   = 8;   // Pixel FIFO depth
	localparam int RSP_LVL_W    = 4;   // FIFO level width

	// Pixel formats held in the FIFO
	typedef enum logic [1:0] {
		RSP_FMT_565 = 2'h0,
		RSP_FMT_666 = 2'h1,
		RSP_FMT_888 = 2'h2
	} rsp_fmt_e;

	// Line phases, one-hot
	typedef enum logic [3:0] {
		RSP_H_SYNC  = 4'h1,
		RSP_H_BACK  = 4'h2,
		RSP_H_ACT   = 4'h4,
		RSP_H_FRONT = 4'h8
	} rsp_hstate_e;

	typedef struct packed {
		logic     en;
		logic     pclk_pol;
		logic     hs_pol;
		logic     vs_pol;
		rsp_fmt_e fmt;
	} rsp_ctrl_s;

	typedef struct packed {
		logic [RSP_TW-1:0] hsw;
		logic [RSP_TW-1:0] line_back_gap;
		logic [RSP_TW-1:0] hact;
		logic [RSP_TW-1:0] line_front_gap;
		logic [RSP_TW-1:0] vsw;
		logic [RSP_TW-1:0] frame_back_gap;
		logic [RSP_TW-1:0] vact;
		logic [RSP_TW-1:0] frame_front_gap;
	} rsp_timing_s;

	typedef struct packed {
		logic                    line_sync_pin;
		logic                    frame_sync_pin;
		logic                    pixel_valid_pin;
		logic                    pixel_clock_pin;
		logic [RSP_COLOUR_W-1:0] colour_bus;
	} rsp_link_s;

	// Reset values
	localparam rsp_ctrl_s   RSP_CTRL_RST = '{en: 1'b0, pclk_pol: 1'b1, hs_pol: 1'b0,
	                                         vs_pol: 1'b0, fmt: RSP_FMT_888};
	localparam rsp_timing_s RSP_TIM_RST  = '{hsw: 12'h002, line_back_gap: 12'h004, hact: 12'h010,
	                                         line_front_gap: 12'h004, vsw: 12'h001, frame_back_gap: 12'h002,
	                                         vact: 12'h008, frame_front_gap: 12'h001};
	localparam logic [RSP_TW-1:0] RSP_DIV_RST = 12'h001;

	// Length minus one, a zero length counts as one
	function automatic logic [RSP_TW-1:0] rsp_m1(input logic [RSP_TW-1:0] x);
		return (x == '0) ? '0 : x - 1'b1;
	endfunction : rsp_m1

endpackage : rsp_pkg

// file: rsp_fifo.sv
// Pixel FIFO with a registered read stage.
// Assumes DEPTH is a power of two; one further word sits in the output stage.
`timescale 1ns/10ps
module rsp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8,
	parameter int LW    = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	// Words held in total
	output logic [LW-1:0]         level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage, no reset needed
	logic [AW-1:0]    wp_q;           // Write pointer
	logic [AW-1:0]    rp_q;           // Read pointer
	logic [AW:0]      cnt_q;          // Words in storage
	logic             push;           // Word accepted
	logic             load;           // Word moved to the output stage

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	// Refill the output stage whenever it empties or is taken
	assign load     = (cnt_q != '0) && (!out_valid || out_ready);
	assign level    = LW'(cnt_q) + LW'(out_valid);

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (load) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	// Output stage, read data come from a register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (load) begin
			out_valid <= 1'b1;
			out_data  <= mem_q[rp_q];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule : rsp_fifo

// file: rsp_panel_if.sv
// Parallel RGB link driver for a dumb colour TFT panel, with AHB-Lite registers.
// Assumes one 10 MHz clock; the pixel clock is divided from it and driven out.
//
// Functional notes
// - Colour TFT class of four panel classes.
// - Drive syncs, strobe, clock and 18 colour lines.
// - Red 17:12, green 11:6, blue 5:0.
// - Wider pixels lose low bits, no dithering.
// - Line sync marks end of line.
// - Frame sync ends frame, panel restarts rows.
// - Strobe active means bus carries valid pixel; on an empty FIFO we still strobe, with black.
// - High polarity: launch falling, panel captures rising.
// - Low polarity: launch rising, panel captures falling.
// - Strobe-only panels get complete waveforms from us.
// - No serial command port toward synchronous panels.
// - Programmable pixel gaps around active line.
// - Programmable line gaps around active frame.
// - Sync active levels selectable independently.
// - Line sync width programmable in pixel clocks.
`timescale 1ns/10ps
module rsp_panel_if
	import rsp_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Panel link
	output rsp_link_s        panel_link
);
	rsp_ctrl_s              ctrl_q;      // Control register
	rsp_timing_s            tim_q;       // Timing registers
	logic [RSP_TW-1:0]      div_q;       // Clock half period in bus cycles
	logic [RSP_TW-1:0]      div_cnt_q;   // Divider count
	logic                   underrun_q;  // Sticky: FIFO empty on a visible pixel
	logic                   wr_q;        // Write data phase pending
	logic [RSP_AW-1:0]      wa_q;        // Write data phase address
	logic [31:0]            rd_d;        // Read mux
	rsp_hstate_e            h_state_q;   // Line phase
	logic [RSP_TW-1:0]      h_cnt_q;     // Pixels left in phase, minus one
	logic [RSP_TW-1:0]      v_line_q;    // Line index in frame
	logic                   ap;          // Address phase taken
	logic                   reg_wr;      // Register write strobe
	logic                   push;        // Pixel word pushed
	logic                   tick;        // Half period enable
	logic                   launch;      // Edge on which the link changes
	logic                   line_end;    // Last pixel of a line
	logic                   vis;         // Visible line
	logic                   act;         // Visible pixel
	logic                   pop;         // Pixel taken from FIFO
	logic                   f_ready;     // FIFO can accept
	logic                   f_valid;     // FIFO head valid
	logic [RSP_PIX_W-1:0]   f_data;      // FIFO head
	logic [RSP_LVL_W-1:0]   f_level;     // FIFO fill
	logic [RSP_TW-1:0]      v_total;     // Lines per frame
	logic [RSP_TW-1:0]      vis_end;     // First line after the visible ones
	logic [RSP_COLOUR_W-1:0] pix_out;    // Reduced pixel

	assign ap      = hsel && htrans[1] && hready;
	assign reg_wr  = wr_q && hreadyout;
	assign push    = wr_q && !hreadyout && f_ready;
	assign v_total = RSP_TW'(tim_q.frame_back_gap + tim_q.vact + tim_q.frame_front_gap);
	assign vis_end = RSP_TW'(tim_q.frame_back_gap + tim_q.vact);

	// Bus handshake; a pixel write waits while the FIFO is full
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q      <= 1'b0;
			wa_q      <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= '0;
		end else begin
			hresp <= 1'b0;
			if (ap) begin
				wr_q <= hwrite;
				wa_q <= haddr[RSP_AW-1:0];
				// Reads answer with no wait
				if (!hwrite) begin
					hrdata <= rd_d;
				end
				// Pixel writes always take the stall path
				if (hwrite && haddr[RSP_AW-1:0] == RSP_OFS_DATA) begin
					hreadyout <= 1'b0;
				end
			end else if (hreadyout || push) begin
				wr_q      <= 1'b0;
				hreadyout <= 1'b1;
			end
		end
	end

	// Read mux, unmapped and write-only offsets read zero
	always_comb begin
		rd_d = '0;
		case (haddr[RSP_AW-1:0])
			RSP_OFS_CTRL: begin
				rd_d[RSP_CTRL_EN]         = ctrl_q.en;
				rd_d[RSP_CTRL_PCLK]       = ctrl_q.pclk_pol;
				rd_d[RSP_CTRL_HSPOL]      = ctrl_q.hs_pol;
				rd_d[RSP_CTRL_VSPOL]      = ctrl_q.vs_pol;
				rd_d[RSP_CTRL_FMT +: 2]   = ctrl_q.fmt;
			end
			RSP_OFS_HSYNC:  rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.hsw;
			RSP_OFS_HPORCH: begin
				rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.line_back_gap;
				rd_d[RSP_HI_LSB +: RSP_TW] = tim_q.line_front_gap;
			end
			RSP_OFS_HACT:   rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.hact;
			RSP_OFS_VSYNC:  rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.vsw;
			RSP_OFS_VPORCH: begin
				rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.frame_back_gap;
				rd_d[RSP_HI_LSB +: RSP_TW] = tim_q.frame_front_gap;
			end
			RSP_OFS_VACT:   rd_d[RSP_LO_LSB +: RSP_TW] = tim_q.vact;
			RSP_OFS_CLKDIV: rd_d[RSP_LO_LSB +: RSP_TW] = div_q;
			RSP_OFS_STATUS: begin
				rd_d[RSP_ST_UNDERRUN]                = underrun_q;
				rd_d[RSP_ST_VIS]                     = vis;
				rd_d[RSP_ST_LVL_LSB +: RSP_LVL_W]    = f_level;
				rd_d[RSP_ST_LINE_LSB +: RSP_TW]      = v_line_q;
			end
			default: rd_d = '0;
		endcase
	end

	// Configuration registers; changes are used from the next bus cycle, not held for a launch edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= RSP_CTRL_RST;
			tim_q  <= RSP_TIM_RST;
			div_q  <= RSP_DIV_RST;
		end else if (reg_wr) begin
			case (wa_q)
				RSP_OFS_CTRL: begin
					ctrl_q.en       <= hwdata[RSP_CTRL_EN];
					ctrl_q.pclk_pol <= hwdata[RSP_CTRL_PCLK];
					ctrl_q.hs_pol   <= hwdata[RSP_CTRL_HSPOL];
					ctrl_q.vs_pol   <= hwdata[RSP_CTRL_VSPOL];
					ctrl_q.fmt      <= rsp_fmt_e'(hwdata[RSP_CTRL_FMT +: 2]);
				end
				RSP_OFS_HSYNC:  tim_q.hsw <= hwdata[RSP_LO_LSB +: RSP_TW];
				RSP_OFS_HPORCH: begin
					tim_q.line_back_gap <= hwdata[RSP_LO_LSB +: RSP_TW];
					tim_q.line_front_gap <= hwdata[RSP_HI_LSB +: RSP_TW];
				end
				RSP_OFS_HACT:   tim_q.hact <= hwdata[RSP_LO_LSB +: RSP_TW];
				RSP_OFS_VSYNC:  tim_q.vsw  <= hwdata[RSP_LO_LSB +: RSP_TW];
				RSP_OFS_VPORCH: begin
					tim_q.frame_back_gap <= hwdata[RSP_LO_LSB +: RSP_TW];
					tim_q.frame_front_gap <= hwdata[RSP_HI_LSB +: RSP_TW];
				end
				RSP_OFS_VACT:   tim_q.vact <= hwdata[RSP_LO_LSB +: RSP_TW];
				RSP_OFS_CLKDIV: div_q      <= hwdata[RSP_LO_LSB +: RSP_TW];
				default: ;
			endcase
		end
	end

	// Underrun flag; a new underrun beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			underrun_q <= 1'b0;
		end else if (launch && act && !f_valid) begin
			underrun_q <= 1'b1;
		end else if (reg_wr && wa_q == RSP_OFS_STATUS && hwdata[RSP_ST_UNDERRUN]) begin
			underrun_q <= 1'b0;
		end
	end

	// Pixel FIFO between the bus and the link
	rsp_fifo #(
		.WIDTH (RSP_PIX_W),
		.DEPTH (RSP_FIFO_D),
		.LW    (RSP_LVL_W)
	) u_fifo (
		.clk       (hclk),
		.rst_n     (hresetn),
		.in_valid  (wr_q && !hreadyout),
		.in_ready  (f_ready),
		.in_data   (hwdata[RSP_PIX_W-1:0]),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data),
		.level     (f_level)
	);

	// Pixel clock divider; the launch edge follows the polarity bit
	assign tick   = ctrl_q.en && (div_cnt_q >= rsp_m1(div_q));
	assign launch = tick && (panel_link.pixel_clock_pin == ctrl_q.pclk_pol);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= '0;
		end else if (tick || !ctrl_q.en) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end

	// Line phase machine, advanced once per pixel period
	assign line_end = launch && (h_state_q == RSP_H_FRONT) && (h_cnt_q == '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			h_state_q <= RSP_H_SYNC;
			h_cnt_q   <= '0;
		end else if (!ctrl_q.en) begin
			h_state_q <= RSP_H_SYNC;
			h_cnt_q   <= rsp_m1(tim_q.hsw);
		end else if (launch) begin
			if (h_cnt_q != '0) begin
				h_cnt_q <= h_cnt_q - 1'b1;
			end else begin
				unique case (h_state_q)
					RSP_H_SYNC: begin
						h_state_q <= RSP_H_BACK;
						h_cnt_q   <= rsp_m1(tim_q.line_back_gap);
					end
					RSP_H_BACK: begin
						h_state_q <= RSP_H_ACT;
						h_cnt_q   <= rsp_m1(tim_q.hact);
					end
					RSP_H_ACT: begin
						h_state_q <= RSP_H_FRONT;
						h_cnt_q   <= rsp_m1(tim_q.line_front_gap);
					end
					RSP_H_FRONT: begin
						h_state_q <= RSP_H_SYNC;
						h_cnt_q   <= rsp_m1(tim_q.hsw);
					end
				endcase
			end
		end
	end

	// Line index; frame sync lines are counted inside the back gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			v_line_q <= '0;
		end else if (!ctrl_q.en) begin
			v_line_q <= '0;
		end else if (line_end) begin
			v_line_q <= (v_line_q >= rsp_m1(v_total)) ? '0 : v_line_q + 1'b1;
		end
	end

	assign vis = (v_line_q >= tim_q.frame_back_gap) && (v_line_q < vis_end);
	assign act = (h_state_q == RSP_H_ACT) && vis;
	// An empty FIFO still strobes, with black, so panel timing never slips
	assign pop = launch && act;

	// Six bits per colour: 888 drops low bits, 565 repeats the top red and blue bit, 666 passes through
	always_comb begin
		unique case (ctrl_q.fmt)
			RSP_FMT_888: pix_out = {f_data[23:18], f_data[15:10], f_data[7:2]};
			RSP_FMT_565: pix_out = {f_data[15:11], f_data[15], f_data[10:5],
			                        f_data[4:0], f_data[4]};
			default:     pix_out = f_data[RSP_COLOUR_W-1:0];
		endcase
	end

	// Link outputs: every pin a register; while running, all but the clock change on the launch edge only.
	// Only syncs, strobe, clock and colour leave; no command channel exists.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			panel_link <= '{line_sync_pin: 1'b1, frame_sync_pin: 1'b1,
			                pixel_valid_pin: 1'b0, pixel_clock_pin: 1'b0, colour_bus: '0};
		end else if (!ctrl_q.en) begin
			panel_link.line_sync_pin   <= ~ctrl_q.hs_pol;
			panel_link.frame_sync_pin  <= ~ctrl_q.vs_pol;
			panel_link.pixel_valid_pin <= 1'b0;
			panel_link.pixel_clock_pin <= 1'b0;
			panel_link.colour_bus      <= '0;
		end else begin
			if (tick) begin
				panel_link.pixel_clock_pin <= ~panel_link.pixel_clock_pin;
			end
			if (launch) begin
				// Sync is active during the first phase of each line
				panel_link.line_sync_pin  <= (h_state_q == RSP_H_SYNC) ?
				                             ctrl_q.hs_pol : ~ctrl_q.hs_pol;
				panel_link.frame_sync_pin <= (v_line_q < tim_q.vsw) ?
				                             ctrl_q.vs_pol : ~ctrl_q.vs_pol;
				panel_link.pixel_valid_pin <= act;
				panel_link.colour_bus      <= (act && f_valid) ? pix_out : '0;
			end
		end
	end

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [RSP_TW-1:0] sync_seen_q;  // Launches spent so far in line sync
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_seen_q <= '0;
		end else if (launch) begin
			sync_seen_q <= (h_state_q == RSP_H_SYNC) ? sync_seen_q + 1'b1 : '0;
		end
	end

	sequence s_off2;
		!ctrl_q.en ##1 !ctrl_q.en;
	endsequence
	sequence s_run_stable;
		ctrl_q.en && $past(ctrl_q.en) && $stable(ctrl_q.pclk_pol);
	endsequence

	property p_idle_colour;
		!panel_link.pixel_valid_pin |-> panel_link.colour_bus == '0;
	endproperty
	a_idle_colour: assert property (p_idle_colour)
		else $error("colour lines not held while strobe idle");

	property p_edge_high;
		s_run_stable and (ctrl_q.pclk_pol && $changed(panel_link.colour_bus))
			|-> !panel_link.pixel_clock_pin;
	endproperty
	a_edge_high: assert property (p_edge_high)
		else $error("colour changed off the falling edge");

	property p_edge_low;
		s_run_stable and (!ctrl_q.pclk_pol && $changed(panel_link.colour_bus))
			|-> panel_link.pixel_clock_pin;
	endproperty
	a_edge_low: assert property (p_edge_low)
		else $error("colour changed off the rising edge");

	// Pins follow the polarity bits one cycle late, so compare with last cycle's setting
	property p_sync_idle;
		s_off2 |-> panel_link.line_sync_pin == ~$past(ctrl_q.hs_pol)
			&& panel_link.frame_sync_pin == ~$past(ctrl_q.vs_pol);
	endproperty
	a_sync_idle: assert property (p_sync_idle)
		else $error("sync not at inactive level while stopped");

	property p_sync_width;
		launch && h_state_q == RSP_H_SYNC && h_cnt_q == '0
			|-> RSP_TW'(sync_seen_q + 1'b1) == (tim_q.hsw == '0 ? 12'h001 : tim_q.hsw);
	endproperty
	a_sync_width: assert property (p_sync_width)
		else $error("line sync width differs from setting");

	property p_trunc888;
		pop && f_valid && ctrl_q.fmt == RSP_FMT_888
			|=> panel_link.colour_bus == {$past(f_data[23:18]), $past(f_data[15:10]),
			                              $past(f_data[7:2])};
	endproperty
	a_trunc888: assert property (p_trunc888)
		else $error("wide pixel not reduced by dropping low bits");

	property p_red_lanes;
		pop && f_valid && ctrl_q.fmt == RSP_FMT_666
			|=> panel_link.colour_bus[17:12] == $past(f_data[17:12]);
	endproperty
	a_red_lanes: assert property (p_red_lanes)
		else $error("red component not on the top six lines");

	property p_frame_wrap;
		line_end && v_line_q >= rsp_m1(v_total) |=> v_line_q == '0;
	endproperty
	a_frame_wrap: assert property (p_frame_wrap)
		else $error("line index did not restart after the frame");

	property p_blank_lines;
		launch && !vis |=> !panel_link.pixel_valid_pin;
	endproperty
	a_blank_lines: assert property (p_blank_lines)
		else $error("strobe active on a gap line");

endmodule : rsp_panel_if

// file: rsp_panel_model.sv
// Behavioural colour TFT panel that latches pixels off the parallel RGB link.
// Assumes its strapping inputs match the controller's polarity settings.
`timescale 1ns/10ps
module rsp_panel_model
	import rsp_pkg::*;
(
	// Link from the controller
	input  wire rsp_link_s   link,
	// Panel strapping
	input  wire logic        pclk_pol,
	input  wire logic        hs_pol,
	input  wire logic        vs_pol
);
	logic [33:0] pix_q[$];  // Row, column and colour of each latched pixel
	logic [7:0]  row;       // Panel line index
	logic [7:0]  col;       // Pixel index within the line
	logic        had;       // Current line received data
	logic        ls_q;      // Line sync seen at the previous capture
	logic        ls;        // Line sync active now
	int          hs_w;      // Running line sync width
	int          hs_last;   // Width of the last complete line sync
	initial begin
		row = '0;
		col = '0;
		had = 1'b0;
		ls_q = 1'b0;
		hs_w = 0;
		hs_last = 0;
	end
	// Capture edge: rising for high polarity, falling for low
	always @(link.pixel_clock_pin) begin
		if (link.pixel_clock_pin === pclk_pol) begin
			ls = (link.line_sync_pin === hs_pol);
			// A new line only counts once the previous one carried pixels
			if (ls && !ls_q) begin
				if (had) row++;
				col = '0;
				had = 1'b0;
			end
			// Frame sync restarts the row index
			if (link.frame_sync_pin === vs_pol) begin
				row = '0;
				col = '0;
				had = 1'b0;
			end
			// Measure the sync pulse in pixel clocks
			if (ls) hs_w++;
			else if (hs_w != 0) begin
				hs_last = hs_w;
				hs_w = 0;
			end
			ls_q = ls;
			// Bus ignored unless the strobe is up
			if (link.pixel_valid_pin === 1'b1) begin
				pix_q.push_back({row, col, link.colour_bus});
				col++;
				had = 1'b1;
			end
		end
	end
endmodule : rsp_panel_model

// file: rsp_panel_if_test.sv
// Self-checking bench for the RGB sync panel interface.
// Assumes the panel model on the link and an AHB-Lite master built from tasks.
`timescale 1ns/10ps
module rsp_panel_if_test
	import rsp_pkg::*;
;
	logic        hclk = 1'b0;     // Bus clock
	logic        hresetn = 1'b0;  // Async reset
	logic        hsel = 1'b0;     // Slave select
	logic [31:0] haddr = '0;      // Address phase
	logic [1:0]  htrans = '0;     // Transfer type
	logic        hwrite = 1'b0;   // Direction
	logic [31:0] hwdata = '0;     // Write data phase
	logic [31:0] hrdata;          // Read data
	logic        hreadyout;       // Also the bus ready
	logic        hresp;           // Always OKAY
	rsp_link_s   panel_link;      // Link to the panel
	logic [2:0]  pol = 3'h1;      // Panel strapping: vs, hs, pclk
	int          bad_count = 0;   // Mismatches
	int          n_checks = 0;    // Comparisons
	logic [23:0] pix [9];         // Pushed pixels
	logic [31:0] cfg [3] = '{32'h22, 32'h0c, 32'h16};  // Format and polarities per run
	logic [31:0] tv [7];          // Timing register values
	logic [31:0] rd;              // Read data
	logic [33:0] got;             // Latched pixel
	int          n;               // Wait bound

	always #50 hclk = ~hclk;

	rsp_panel_if i_rsp_panel_if (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .panel_link(panel_link));
	rsp_panel_model i_rsp_panel_model (.link(panel_link), .pclk_pol(pol[0]), .hs_pol(pol[1]),
		.vs_pol(pol[2]));

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test

	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// One single word transfer; waits are bounded, a hang ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 1000);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 1000);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
		if (k >= 1000) begin
			bad_count++;
			finish_test();
		end
	endtask : bus

	// Expected colour lines: keep the top bits of each component
	function automatic logic [31:0] exp_col(input logic [1:0] f, input logic [23:0] p);
		if (f == 2'h2) return {14'h0, p[23:18], p[15:10], p[7:2]};
		if (f == 2'h0) return {14'h0, p[15:11], p[15], p[10:5], p[4:0], p[4]};
		return {14'h0, p[17:0]};
	endfunction : exp_col

	// Main sequence: reset values, then per format and polarity set one frame and two pixels of the next
	initial begin
		void'($urandom(32'hdf0aa360));
		repeat (2) @(posedge hclk);
		chk(32'(panel_link), 32'h0030_0000);
		hresetn <= 1'b1;
		bus(1'b0, RSP_OFS_CTRL, '0, rd);
		chk(rd, 32'h22);
		bus(1'b0, RSP_OFS_HACT, '0, rd);
		chk(rd, 32'h10);
		bus(1'b0, 8'h40, '0, rd);
		chk(rd, 32'h0);
		bus(1'b0, RSP_OFS_DATA, '0, rd);
		chk(rd, 32'h0);
		for (int r = 0; r < 3; r++) begin
			bus(1'b1, RSP_OFS_CTRL, cfg[r], rd);
			pol = cfg[r][3:1];
			// Divider of four gives an 800 ns pixel clock
			tv = '{32'(r + 1), 32'h10001, 32'h4, 32'h1, 32'h10002, 32'h2, 32'h4};
			for (int i = 0; i < 7; i++) bus(1'b1, 8'(4 + 4 * i), tv[i], rd);
			// Fill the FIFO to its full level while the link is stopped
			for (int i = 0; i < 9; i++) begin
				pix[i] = 24'($urandom);
				bus(1'b1, RSP_OFS_DATA, {8'h0, pix[i]}, rd);
			end
			bus(1'b0, RSP_OFS_STATUS, '0, rd);
			chk({28'h0, rd[7:4]}, 32'h9);
			i_rsp_panel_model.pix_q.delete();
			bus(1'b1, RSP_OFS_CTRL, cfg[r] | 32'h1, rd);
			for (n = 0; n < 5000 && i_rsp_panel_model.pix_q.size() < 10; n++) @(posedge hclk);
			if (n == 5000) begin
				bad_count++;
				finish_test();
			end
			bus(1'b1, RSP_OFS_CTRL, cfg[r], rd);
			repeat (4) @(posedge hclk);
			chk({29'h0, panel_link.line_sync_pin, panel_link.frame_sync_pin,
				panel_link.pixel_valid_pin}, {29'h0, ~cfg[r][2], ~cfg[r][3], 1'b0});
			// Second frame ran dry after one pixel
			bus(1'b0, RSP_OFS_STATUS, '0, rd);
			chk({31'h0, rd[0]}, 32'h1);
			bus(1'b1, RSP_OFS_STATUS, 32'h1, rd);
			bus(1'b0, RSP_OFS_STATUS, '0, rd);
			chk({31'h0, rd[0]}, 32'h0);
			for (int k = 0; k < 10; k++) begin
				got = i_rsp_panel_model.pix_q[k];
				chk({14'h0, got[17:0]}, (k < 9) ? exp_col(cfg[r][5:4], pix[k]) : '0);
				chk({16'h0, got[33:18]}, (k < 8) ? 32'((k / 4) << 8 | k % 4) : 32'(k - 8));
			end
			chk(32'(i_rsp_panel_model.hs_last), 32'(r + 1));
		end
		finish_test();
	end
endmodule : rsp_panel_if_test
